// ===== sndpe_core.sv
// Serial NAND page program and block erase sequencer with its cache and status bits.
//
// Function
// - Load: four dummy bits, 12-bit column, data.
// - One load takes one to 2112 bytes.
// - Bytes past cache capacity are dropped.
// - Chip select rising aborts the transfer.
// - Write-enable command sets the write latch.
// - Execute without latch ignored, program error zero.
// - Execute: 24-bit row, cache to page, busy.
// - Status read at C0H shows busy, fail flags.
// - Failed program sets program error flag.
// - Random load changes only addressed cache bytes.
// - Quad IO random load sends address on four lines.
// - Erase: 24-bit block row, busy erase time.
// - Erase end clears busy, failure sets flag.
// - Cache loads accepted while erase busy.
// - Program error cleared by execute and reset.
// - Erase error cleared at erase start.
`timescale 1ns/1ps
module sndpe_core
  import sndpe_pkg::*;
#(
  parameter int PROG_TIME_NS = 300000,
  parameter int ERASE_TIME_NS = 1000000,
  parameter int ROW_ADDR_BITS = 16
) (
  // Core clock and reset.
  input wire logic clk_in,
  input wire logic reset_in,
  // Serial link.
  input wire logic link_clk_in,
  input wire logic chip_select_n_in,
  input wire logic io_line_0_in,
  input wire logic io_line_1_in,
  input wire logic io_line_2_in,
  input wire logic io_line_3_in,
  output logic io_line_1_out,
  output logic io_line_1_oe_out,
  // Configuration from the feature register.
  input wire logic quad_io_enable_bit_in,
  // Status bits.
  output logic operation_in_progress_out,
  output logic write_latch_bit_out,
  output logic program_error_flag_out,
  output logic erase_error_flag_out,
  // Array side.
  output logic [ROW_W-1:0] array_row_out,
  output logic array_program_out,
  output logic array_erase_out,
  output logic [COL_W-1:0] array_column_out,
  output logic [7:0] array_data_out,
  output logic array_data_valid_out
);

  // ****************************************
  // Timing
  // ****************************************
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Link domain declarations
  // ****************************************
  sndpe_link_t lk_state_reg;
  logic [4:0] cnt_reg;
  logic [31:0] sh_reg;
  logic [12:0] col_reg;
  logic quad_data_reg;
  logic quad_addr_reg;
  logic is_erase_reg;
  logic [7:0] sout_reg;
  logic quad_s1_reg;
  logic quad_s2_reg;
  logic [3:0] stat_s1_reg;
  logic [3:0] stat_s2_reg;
  logic evt_tgl_reg;
  sndpe_evt_t evt_code_reg;
  logic [ROW_W-1:0] evt_row_reg;
  logic [31:0] in1;
  logic [31:0] in4;
  logic [7:0] opc;
  logic cmd_done;
  logic addr_done;
  logic byte_done;
  logic row_done;
  logic evt_fire;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] stat_byte;

  // ****************************************
  // Core domain declarations
  // ****************************************
  sndpe_core_t cs_state_reg;
  logic tgl_s1_reg;
  logic tgl_s2_reg;
  logic tgl_s3_reg;
  logic evt_pulse;
  logic [31:0] busy_cnt_reg;
  logic [COL_W-1:0] rd_addr_reg;
  logic sweep_reg;
  logic [7:0] rd_data;
  logic row_bad;

  // ****************************************
  // Link receive path
  // ****************************************
  // Shift values for one-line and four-line phases, most significant bit first.
  assign in1 = {sh_reg[30:0], io_line_0_in};
  assign in4 = {sh_reg[27:0], io_line_3_in, io_line_2_in, io_line_1_in, io_line_0_in};
  assign opc = in1[7:0];
  assign cmd_done = (lk_state_reg == LK_CMD) && (cnt_reg == OP_LAST);
  assign addr_done = (lk_state_reg == LK_ADDR) &&
                     (cnt_reg == (quad_addr_reg ? COL_LAST_X4 : COL_LAST_X1));
  assign byte_done = (lk_state_reg == LK_DATA) &&
                     (cnt_reg == (quad_data_reg ? BYTE_LAST_X4 : BYTE_LAST_X1));
  assign row_done = (lk_state_reg == LK_ROW) && (cnt_reg == ROW_LAST);
  assign wr_data = quad_data_reg ? in4[7:0] : in1[7:0];
  // Writes land only inside the cache; extra bytes are dropped and only addressed bytes change.
  assign wr_en = byte_done && (col_reg < CACHE_BYTES);
  assign evt_fire = (cmd_done && ((opc == OP_WREN) || (opc == OP_RESET))) || row_done;
  // Status byte as seen by the link, built from synchronised core bits.
  assign stat_byte = {4'h0, stat_s2_reg};

  // Frame logic; chip select high resets it, so an early rise aborts any phase.
  always_ff @(posedge link_clk_in or posedge chip_select_n_in) begin
    if (chip_select_n_in) begin
      lk_state_reg <= LK_CMD;
      cnt_reg <= 5'h00;
      sh_reg <= 32'h00000000;
      col_reg <= 13'h0000;
      quad_data_reg <= 1'b0;
      quad_addr_reg <= 1'b0;
      is_erase_reg <= 1'b0;
      sout_reg <= 8'h00;
      io_line_1_out <= 1'b0;
      io_line_1_oe_out <= 1'b0;
    end else begin
      unique case (lk_state_reg)
        LK_CMD: begin
          sh_reg <= in1;
          cnt_reg <= cnt_reg + STEP_X1;
          if (cmd_done) begin
            cnt_reg <= 5'h00;
            quad_data_reg <= 1'b0;
            quad_addr_reg <= 1'b0;
            if ((opc == OP_LOAD) || (opc == OP_RAND)) begin
              lk_state_reg <= LK_ADDR;
            end else if ((opc == OP_LOAD_X4 || opc == OP_RAND_X4A || opc == OP_RAND_X4B)
                         && quad_s2_reg) begin
              quad_data_reg <= 1'b1;
              lk_state_reg <= LK_ADDR;
            end else if ((opc == OP_RAND_QIO) && quad_s2_reg) begin
              quad_data_reg <= 1'b1;
              quad_addr_reg <= 1'b1;
              lk_state_reg <= LK_ADDR;
            end else if ((opc == OP_EXEC) || (opc == OP_ERASE)) begin
              is_erase_reg <= (opc == OP_ERASE);
              lk_state_reg <= LK_ROW;
            end else if (opc == OP_GETF) begin
              lk_state_reg <= LK_FADDR;
            end else begin
              lk_state_reg <= LK_IGNORE;
            end
          end
        end
        LK_ADDR: begin
          sh_reg <= quad_addr_reg ? in4 : in1;
          cnt_reg <= cnt_reg + (quad_addr_reg ? STEP_X4 : STEP_X1);
          if (addr_done) begin
            // The dummy bits fall away; the low twelve bits pick the first byte.
            col_reg <= {1'b0, (quad_addr_reg ? in4[COL_W-1:0] : in1[COL_W-1:0])};
            cnt_reg <= 5'h00;
            lk_state_reg <= LK_DATA;
          end
        end
        LK_DATA: begin
          sh_reg <= quad_data_reg ? in4 : in1;
          cnt_reg <= cnt_reg + (quad_data_reg ? STEP_X4 : STEP_X1);
          if (byte_done) begin
            cnt_reg <= 5'h00;
            if (col_reg != COL_LIMIT) begin
              col_reg <= col_reg + 13'h0001;
            end
          end
        end
        LK_ROW: begin
          sh_reg <= in1;
          cnt_reg <= cnt_reg + STEP_X1;
          if (row_done) begin
            lk_state_reg <= LK_IGNORE;
          end
        end
        LK_FADDR: begin
          sh_reg <= in1;
          cnt_reg <= cnt_reg + STEP_X1;
          if (cnt_reg == OP_LAST) begin
            if (in1[7:0] == FEAT_STATUS) begin
              io_line_1_out <= stat_byte[7];
              io_line_1_oe_out <= 1'b1;
              sout_reg <= {stat_byte[6:0], stat_byte[7]};
              lk_state_reg <= LK_SOUT;
            end else begin
              lk_state_reg <= LK_IGNORE;
            end
          end
        end
        LK_SOUT: begin
          // The status byte repeats for as long as the host keeps clocking.
          io_line_1_out <= sout_reg[7];
          sout_reg <= {sout_reg[6:0], sout_reg[7]};
        end
        LK_IGNORE: begin
          cnt_reg <= 5'h00;
        end
      endcase
    end
  end

  // Command events toward the core: data words are held while the toggle crosses.
  always_ff @(posedge link_clk_in or posedge reset_in) begin
    if (reset_in) begin
      evt_tgl_reg <= 1'b0;
      evt_code_reg <= EV_WREN;
      evt_row_reg <= 24'h000000;
    end else if (evt_fire) begin
      evt_tgl_reg <= ~evt_tgl_reg;
      evt_row_reg <= in1[ROW_W-1:0];
      if (row_done) begin
        evt_code_reg <= is_erase_reg ? EV_ERASE : EV_EXEC;
      end else begin
        evt_code_reg <= (opc == OP_WREN) ? EV_WREN : EV_RESET;
      end
    end
  end

  // Quad enable and status bits synchronised into the link clock.
  always_ff @(posedge link_clk_in or posedge reset_in) begin
    if (reset_in) begin
      quad_s1_reg <= 1'b0;
      quad_s2_reg <= 1'b0;
      stat_s1_reg <= 4'h0;
      stat_s2_reg <= 4'h0;
    end else begin
      quad_s1_reg <= quad_io_enable_bit_in;
      quad_s2_reg <= quad_s1_reg;
      stat_s1_reg <= {program_error_flag_out, erase_error_flag_out,
                      write_latch_bit_out, operation_in_progress_out};
      stat_s2_reg <= stat_s1_reg;
    end
  end

  // ****************************************
  // Cache memory
  // ****************************************
  // The cache has its own ports, so loads proceed while the array is busy.
  sndpe_cache_mem #(
    .DEPTH(int'(CACHE_BYTES)),
    .AW(COL_W),
    .DW(8)
  ) u_cache (
    .wr_clk_in(link_clk_in),
    .wr_en_in(wr_en),
    .wr_addr_in(col_reg[COL_W-1:0]),
    .wr_data_in(wr_data),
    .rd_clk_in(clk_in),
    .rd_addr_in(rd_addr_reg),
    .rd_data_out(rd_data)
  );

  // ****************************************
  // Core domain
  // ****************************************
  // Event toggle synchroniser; the edge is taken between the second and third stage.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
    end else begin
      tgl_s1_reg <= evt_tgl_reg;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
    end
  end

  assign evt_pulse = tgl_s2_reg ^ tgl_s3_reg;
  // Rows beyond the populated address range are refused by the array.
  assign row_bad = (evt_row_reg[ROW_W-1:ROW_ADDR_BITS] != '0);

  // Operation sequencer, busy timer and status flags; a set wins over a clear.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cs_state_reg <= CS_IDLE;
      busy_cnt_reg <= 32'h00000000;
      operation_in_progress_out <= 1'b0;
      write_latch_bit_out <= 1'b0;
      program_error_flag_out <= 1'b0;
      erase_error_flag_out <= 1'b0;
      array_row_out <= 24'h000000;
      array_program_out <= 1'b0;
      array_erase_out <= 1'b0;
    end else begin
      array_program_out <= 1'b0;
      array_erase_out <= 1'b0;
      unique case (cs_state_reg)
        CS_IDLE: begin
          if (evt_pulse && (evt_code_reg == EV_EXEC)) begin
            program_error_flag_out <= 1'b0;
            if (write_latch_bit_out) begin
              cs_state_reg <= CS_PROG;
              busy_cnt_reg <= 32'(PROG_CYCLES - 1);
              operation_in_progress_out <= 1'b1;
              array_row_out <= evt_row_reg;
              array_program_out <= 1'b1;
            end
          end else if (evt_pulse && (evt_code_reg == EV_ERASE) && write_latch_bit_out) begin
            erase_error_flag_out <= 1'b0;
            cs_state_reg <= CS_ERASE;
            busy_cnt_reg <= 32'(ERASE_CYCLES - 1);
            operation_in_progress_out <= 1'b1;
            array_row_out <= evt_row_reg;
            array_erase_out <= 1'b1;
          end
        end
        CS_PROG: begin
          busy_cnt_reg <= busy_cnt_reg - 32'h00000001;
          if (busy_cnt_reg == 32'h00000000) begin
            cs_state_reg <= CS_IDLE;
            operation_in_progress_out <= 1'b0;
            write_latch_bit_out <= 1'b0;
            program_error_flag_out <= row_bad;
          end
        end
        CS_ERASE: begin
          busy_cnt_reg <= busy_cnt_reg - 32'h00000001;
          if (busy_cnt_reg == 32'h00000000) begin
            cs_state_reg <= CS_IDLE;
            operation_in_progress_out <= 1'b0;
            write_latch_bit_out <= 1'b0;
            erase_error_flag_out <= row_bad;
          end
        end
      endcase
      // Reset clears the fail flags and the latch unless an end sets them now.
      if (evt_pulse && (evt_code_reg == EV_RESET)) begin
        write_latch_bit_out <= 1'b0;
        if (!((cs_state_reg == CS_PROG) && (busy_cnt_reg == 32'h00000000))) begin
          program_error_flag_out <= 1'b0;
        end
        if (!((cs_state_reg == CS_ERASE) && (busy_cnt_reg == 32'h00000000))) begin
          erase_error_flag_out <= 1'b0;
        end
      end
      // The write-enable command sets the latch and wins over any clear.
      if (evt_pulse && (evt_code_reg == EV_WREN)) begin
        write_latch_bit_out <= 1'b1;
      end
    end
  end

  // Cache sweep toward the array at the start of a program.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rd_addr_reg <= 12'h000;
      sweep_reg <= 1'b0;
      array_data_valid_out <= 1'b0;
      array_column_out <= 12'h000;
      array_data_out <= 8'h00;
    end else begin
      array_data_valid_out <= sweep_reg;
      array_column_out <= rd_addr_reg - 12'h001;
      array_data_out <= rd_data;
      if (array_program_out) begin
        sweep_reg <= 1'b1;
        rd_addr_reg <= 12'h001;
        array_column_out <= 12'h000;
      end else if (sweep_reg) begin
        if ({1'b0, rd_addr_reg} == CACHE_BYTES) begin
          sweep_reg <= 1'b0;
        end else begin
          rd_addr_reg <= rd_addr_reg + 12'h001;
        end
      end else begin
        rd_addr_reg <= 12'h000;
      end
    end
  end

endmodule : sndpe_core

// ===== sndpe_pkg.sv
// Shared opcodes, field positions, sizes and state types of the program and erase sequencer.
package sndpe_pkg;

  // ****************************************
  // Command opcodes and feature addresses
  // ****************************************
  localparam logic [7:0] OP_LOAD = 8'h02;
  localparam logic [7:0] OP_LOAD_X4 = 8'h32;
  localparam logic [7:0] OP_RAND = 8'h84;
  localparam logic [7:0] OP_RAND_X4A = 8'hC4;
  localparam logic [7:0] OP_RAND_X4B = 8'h34;
  localparam logic [7:0] OP_RAND_QIO = 8'h72;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_EXEC = 8'h10;
  localparam logic [7:0] OP_ERASE = 8'hD8;
  localparam logic [7:0] OP_RESET = 8'hFF;
  localparam logic [7:0] OP_GETF = 8'h0F;
  localparam logic [7:0] FEAT_STATUS = 8'hC0;

  // ****************************************
  // Sizes, phase lengths and status bit positions
  // ****************************************
  localparam logic [12:0] CACHE_BYTES = 13'h0840;
  localparam logic [12:0] COL_LIMIT = 13'h1FFF;
  localparam int COL_W = 12;
  localparam int ROW_W = 24;
  localparam logic [4:0] OP_LAST = 5'h07;
  localparam logic [4:0] COL_LAST_X1 = 5'h0F;
  localparam logic [4:0] COL_LAST_X4 = 5'h0C;
  localparam logic [4:0] ROW_LAST = 5'h17;
  localparam logic [4:0] BYTE_LAST_X1 = 5'h07;
  localparam logic [4:0] BYTE_LAST_X4 = 5'h04;
  localparam logic [4:0] STEP_X1 = 5'h01;
  localparam logic [4:0] STEP_X4 = 5'h04;
  localparam int ST_OIP = 0;
  localparam int ST_WEL = 1;
  localparam int ST_EFAIL = 2;
  localparam int ST_PFAIL = 3;
  localparam int CLK_PERIOD_NS = 8;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {EV_WREN, EV_EXEC, EV_ERASE, EV_RESET} sndpe_evt_t;
  typedef enum {LK_CMD, LK_ADDR, LK_DATA, LK_ROW, LK_FADDR, LK_SOUT, LK_IGNORE} sndpe_link_t;
  typedef enum {CS_IDLE, CS_PROG, CS_ERASE} sndpe_core_t;

endpackage : sndpe_pkg

// ===== sndpe_cache_mem.sv
// Page cache memory: written from the serial link clock, read with a registered port.
`timescale 1ns/1ps
module sndpe_cache_mem #(
  parameter int DEPTH = 2112,
  parameter int AW = 12,
  parameter int DW = 8
) (
  // Write port.
  input wire logic wr_clk_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [DW-1:0] wr_data_in,
  // Read port.
  input wire logic rd_clk_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [DW-1:0] rd_data_out
);

  logic [DW-1:0] mem [DEPTH];

  // Stores one byte per link edge that completes a byte.
  always_ff @(posedge wr_clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  // Registered read so the array sweep sees a flop output.
  always_ff @(posedge rd_clk_in) begin
    rd_data_out <= mem[rd_addr_in];
  end

endmodule : sndpe_cache_mem

// ===== sndpe_core_sva.sv
// Concurrent checks on the ports of the program and erase sequencer.
`timescale 1ns/1ps
module sndpe_core_sva
  import sndpe_pkg::*;
#(
  parameter int PROG_TIME_NS = 300000,
  parameter int ERASE_TIME_NS = 1000000,
  parameter int ROW_ADDR_BITS = 16
) (
  // Core clock, reset and framing.
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic chip_select_n_in,
  // Observed outputs.
  input wire logic io_line_1_oe_out,
  input wire logic operation_in_progress_out,
  input wire logic write_latch_bit_out,
  input wire logic program_error_flag_out,
  input wire logic erase_error_flag_out,
  input wire logic [ROW_W-1:0] array_row_out,
  input wire logic array_program_out,
  input wire logic array_erase_out,
  input wire logic [COL_W-1:0] array_column_out,
  input wire logic array_data_valid_out
);
  localparam int PCYC = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ECYC = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  int busy_cnt_reg;
  logic erase_kind_reg;
  logic row_bad;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // Counts the busy cycles that follow each start pulse.
  always_ff @(posedge clk_in) begin
    if (reset_in) busy_cnt_reg <= 0;
    else if (array_program_out || array_erase_out) busy_cnt_reg <= 1;
    else if (operation_in_progress_out) busy_cnt_reg <= busy_cnt_reg + 1;
  end
  // Remembers whether the running operation is an erase.
  always_ff @(posedge clk_in) begin
    if (reset_in) erase_kind_reg <= 1'b0;
    else if (array_erase_out) erase_kind_reg <= 1'b1;
    else if (array_program_out) erase_kind_reg <= 1'b0;
  end
  // Row bits above the implemented range make an operation fail.
  assign row_bad = (array_row_out >> ROW_ADDR_BITS) != '0;
  // ****
  // Assertions
  // ****
  a_oe_idle_low: assert property (
    chip_select_n_in |-> !io_line_1_oe_out) else $error("Line driven outside a frame.");
  a_start_when_idle: assert property (
    (array_program_out || array_erase_out) |-> !$past(operation_in_progress_out))
    else $error("Operation started while busy.");
  a_start_sets_busy: assert property (
    (array_program_out || array_erase_out) |-> operation_in_progress_out && write_latch_bit_out)
    else $error("Start without busy or latch.");
  a_busy_length: assert property (
    $fell(operation_in_progress_out) |-> busy_cnt_reg == (erase_kind_reg ? ECYC : PCYC))
    else $error("Busy time is wrong.");
  a_done_clears_latch: assert property (
    $fell(operation_in_progress_out) |-> !write_latch_bit_out) else $error("Latch kept at end.");
  a_prog_result: assert property (
    $fell(operation_in_progress_out) && !erase_kind_reg |-> program_error_flag_out == row_bad)
    else $error("Program result flag is wrong.");
  a_erase_result: assert property (
    $fell(operation_in_progress_out) && erase_kind_reg |-> erase_error_flag_out == row_bad)
    else $error("Erase result flag is wrong.");
  a_prog_clears_err: assert property (
    array_program_out |=> !program_error_flag_out [*2]) else $error("Program error not cleared.");
  a_erase_clears_err: assert property (
    array_erase_out |=> !erase_error_flag_out) else $error("Erase error not cleared.");
  a_sweep_start: assert property (
    array_program_out |-> ##2 (array_data_valid_out && array_column_out == '0))
    else $error("Cache sweep did not start.");
  a_sweep_step: assert property (
    array_data_valid_out && array_column_out != 12'h83F |=>
    array_data_valid_out && array_column_out == $past(array_column_out) + 12'h001)
    else $error("Cache sweep broke off.");
endmodule : sndpe_core_sva

bind sndpe_core sndpe_core_sva #(
  .PROG_TIME_NS(PROG_TIME_NS), .ERASE_TIME_NS(ERASE_TIME_NS), .ROW_ADDR_BITS(ROW_ADDR_BITS)
) u_sva (
  .clk_in(clk_in), .reset_in(reset_in), .chip_select_n_in(chip_select_n_in),
  .io_line_1_oe_out(io_line_1_oe_out), .operation_in_progress_out(operation_in_progress_out),
  .write_latch_bit_out(write_latch_bit_out), .program_error_flag_out(program_error_flag_out),
  .erase_error_flag_out(erase_error_flag_out), .array_row_out(array_row_out),
  .array_program_out(array_program_out), .array_erase_out(array_erase_out),
  .array_column_out(array_column_out), .array_data_valid_out(array_data_valid_out)
);

// ===== sndpe_host.sv
// Serial host model that frames commands towards the sequencer.
`timescale 1ns/1ps
module sndpe_host (
  // Link driven by the host.
  output logic link_clk_out,
  output logic chip_select_n_out,
  output logic io_line_0_out,
  output logic io_line_1_out,
  output logic io_line_2_out,
  output logic io_line_3_out,
  // Resolved level of the shared line.
  input wire logic io_line_1_in
);
  logic [7:0] rx_reg;
  logic [7:0] tx_q[$];
  logic tog = 1'b0;
  // Link idle: clock stopped low, frame closed; the select rises as an update so it is an edge.
  initial begin
    link_clk_out = 1'b0;
    chip_select_n_out <= 1'b1;
    {io_line_3_out, io_line_2_out, io_line_1_out, io_line_0_out} = 4'h5;
  end
  // One link bit: lines change mid-low, the device samples on the rise.
  task automatic tick(input logic [3:0] v, input bit q);
    tog = ~tog;
    {io_line_3_out, io_line_2_out, io_line_1_out, io_line_0_out} =
      q ? v : {tog, ~tog, tog, v[0]};
    #20 link_clk_out = 1'b1;
    #40 link_clk_out = 1'b0;
    rx_reg = {rx_reg[6:0], io_line_1_in};
    #20;
  endtask : tick
  // Whole frame: opcode, address, queued bytes, stray bits, then read bits.
  task automatic frame(input logic [7:0] op, input int abits, input logic [23:0] adr,
                       input bit qa, input bit qd, input int xbits, input int rbits,
                       output logic [7:0] st);
    int step;
    logic [7:0] b;
    #($urandom_range(7, 1));
    chip_select_n_out = 1'b0;
    #20;
    for (int i = 7; i >= 0; i--) tick({3'h0, op[i]}, 1'b0);
    step = qa ? 4 : 1;
    for (int i = abits - step; i >= 0; i -= step) tick(4'(adr >> i), qa);
    while (tx_q.size() > 0) begin
      b = tx_q.pop_front();
      if (qd) begin
        tick(b[7:4], 1'b1);
        tick(b[3:0], 1'b1);
      end else begin
        for (int i = 7; i >= 0; i--) tick({3'h0, b[i]}, 1'b0);
      end
    end
    repeat (xbits) tick(4'hF, 1'b0);
    repeat (rbits) tick(4'h0, 1'b0);
    st = rx_reg;
    #20 chip_select_n_out = 1'b1;
    {io_line_3_out, io_line_2_out, io_line_1_out, io_line_0_out} =
      ~{io_line_3_out, io_line_2_out, io_line_1_out, io_line_0_out};
    #160;
  endtask : frame
endmodule : sndpe_host

// ===== tb_sndpe_core.sv
// Self-checking bench for the page program and block erase sequencer.
`timescale 1ns/1ps
module tb_sndpe_core;
  import sndpe_pkg::*;
  localparam int RAB = 16;
  logic clk_in = 1'b0;
  logic reset_in = 1'b0;
  logic quad_io_enable_bit_in = 1'b0;
  logic link_clk, cs_n, io0, io1_h, io2, io3, io1_w, io1_out, io1_oe;
  logic operation_in_progress, write_latch_bit, perr, eerr, prog_p, erase_p, dvalid;
  logic [ROW_W-1:0] row;
  logic [COL_W-1:0] col;
  logic [7:0] dat, st_seen;
  logic [7:0] cache_m[int];
  logic [19:0] sweep_q[$];
  logic [19:0] sw_e;
  logic [7:0] st_q[$];
  logic [7:0] qops[4] = '{OP_LOAD_X4, OP_RAND_X4A, OP_RAND_X4B, OP_RAND_QIO};
  int err_count = 0;
  int tests_run = 0;
  int pn = 0;
  int en = 0;
  logic pe = 1'b0, ee = 1'b0, wl = 1'b0, busy = 1'b0;
  event st_ev;
  // Shared line level from both drivers.
  assign io1_w = io1_oe ? io1_out : io1_h;
  always #4 clk_in = ~clk_in;
  sndpe_core #(.PROG_TIME_NS(20000), .ERASE_TIME_NS(8000), .ROW_ADDR_BITS(RAB)) dut (
    .clk_in(clk_in), .reset_in(reset_in), .link_clk_in(link_clk), .chip_select_n_in(cs_n),
    .io_line_0_in(io0), .io_line_1_in(io1_w), .io_line_2_in(io2), .io_line_3_in(io3),
    .io_line_1_out(io1_out), .io_line_1_oe_out(io1_oe),
    .quad_io_enable_bit_in(quad_io_enable_bit_in), .operation_in_progress_out(operation_in_progress),
    .write_latch_bit_out(write_latch_bit), .program_error_flag_out(perr), .erase_error_flag_out(eerr),
    .array_row_out(row), .array_program_out(prog_p), .array_erase_out(erase_p),
    .array_column_out(col), .array_data_out(dat), .array_data_valid_out(dvalid));
  sndpe_host host (
    .link_clk_out(link_clk), .chip_select_n_out(cs_n), .io_line_0_out(io0),
    .io_line_1_out(io1_h), .io_line_2_out(io2), .io_line_3_out(io3), .io_line_1_in(io1_w));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  // Result watcher: start pulses, cache bytes leaving for the array, status reads.
  always @(posedge clk_in) begin
    if (prog_p === 1'b1) pn++;
    if (erase_p === 1'b1) en++;
    if (dvalid === 1'b1 && sweep_q.size() > 0 && col === sweep_q[0][19:8]) begin
      sw_e = sweep_q.pop_front();
      check(dat, sw_e[7:0]);
    end
  end
  always @(st_ev) check(st_seen, st_q.pop_front());
  task automatic cmd(input logic [7:0] op);
    logic [7:0] s;
    host.frame(op, 0, 24'h0, 1'b0, 1'b0, 0, 0, s);
    if (op == OP_WREN) wl = 1'b1;
    if (op == OP_RESET) {pe, ee, wl} = 3'h0;
  endtask : cmd
  task automatic stat();
    st_q.push_back({4'h0, pe, ee, wl, busy});
    host.frame(OP_GETF, 8, 24'(FEAT_STATUS), 1'b0, 1'b0, 0, 7, st_seen);
    -> st_ev;
  endtask : stat
  task automatic load(input logic [7:0] op, input int c, input int n, input int xb);
    logic [7:0] s, b;
    bit qd;
    qd = op inside {OP_LOAD_X4, OP_RAND_X4A, OP_RAND_X4B, OP_RAND_QIO};
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom);
      host.tx_q.push_back(b);
      if ((!qd || quad_io_enable_bit_in) && c + i < int'(CACHE_BYTES)) cache_m[c + i] = b;
    end
    host.frame(op, 16, {8'h0, 4'hA, 12'(c)}, op == OP_RAND_QIO, qd, xb, 0, s);
  endtask : load
  // Program or erase with optional write enable, polling and a mid-erase load.
  task automatic run(input logic [7:0] op, input logic [23:0] r, input bit we, input bit mid);
    logic [7:0] s;
    int n0;
    n0 = pn + en;
    if (we) cmd(OP_WREN);
    if (op == OP_EXEC && wl) foreach (cache_m[c]) sweep_q.push_back({12'(c), cache_m[c]});
    host.frame(op, 24, r, 1'b0, 1'b0, 0, 0, s);
    if (op == OP_EXEC) pe = 1'b0;
    else if (wl) ee = 1'b0;
    busy = wl;
    if (mid) begin
      stat();
      load(OP_LOAD, 100, 2, 0);
    end
    repeat (40) begin
      host.frame(OP_GETF, 8, 24'(FEAT_STATUS), 1'b0, 1'b0, 0, 7, s);
      if (s[ST_OIP] === 1'b0) break;
    end
    check(8'(pn + en - n0), {7'h0, wl});
    if (wl) check(row[7:0], r[7:0]);
    if (wl) check(row[23:16], r[23:16]);
    if (wl && op == OP_EXEC) pe = (r >> RAB) != 0;
    if (wl && op == OP_ERASE) ee = (r >> RAB) != 0;
    {busy, wl} = 2'h0;
    stat();
    check(8'(sweep_q.size()), 8'h00);
  endtask : run
  // Main sequence.
  initial begin
    void'($urandom(32'h088E));
    // Reset rises as an update so the link flops see a real edge.
    reset_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    stat();
    load(OP_LOAD, 0, 4, 0);
    load(OP_LOAD, 2110, 4, 0);
    load(OP_LOAD, 30, 2, 0);
    load(OP_LOAD, 30, 1, 4);
    load(OP_LOAD_X4, 40, 2, 0);
    @(posedge clk_in);
    quad_io_enable_bit_in <= 1'b1;
    @(posedge clk_in);
    for (int i = 0; i < 4; i++) load(qops[i], 50 + 16 * i, 3, 0);
    load(OP_RAND, 2, 1, 0);
    cmd(OP_WREN);
    stat();
    run(OP_EXEC, 24'h000123, 1'b0, 1'b0);
    run(OP_EXEC, 24'h010040, 1'b1, 1'b0);
    run(OP_EXEC, 24'h000200, 1'b0, 1'b0);
    run(OP_EXEC, 24'h020000, 1'b1, 1'b0);
    cmd(OP_RESET);
    stat();
    run(OP_ERASE, 24'h000040, 1'b0, 1'b0);
    run(OP_ERASE, 24'h030000, 1'b1, 1'b1);
    run(OP_ERASE, 24'h000080, 1'b1, 1'b0);
    run(OP_EXEC, 24'h000300, 1'b1, 1'b0);
    end_of_test();
  end
  // Watchdog against a hang.
  initial begin
    #600000;
    err_count++;
    end_of_test();
  end
endmodule : tb_sndpe_core
